// ==== tb/io_bus_poll_interface_tb.sv ====
// self-checking bench: apb access, card bus commands, sector decode and dma
`timescale 1ns/1ps
module io_bus_poll_interface_tb;
    import ipb_pkg::*;
    localparam logic [4:0] TB_DEV  = 5'h13;
    localparam logic [1:0] TB_SECT = 2'h2;
    localparam logic [1:0] QRY = 2'h0, REL = 2'h1, STS = 2'h2, KEP = 2'h3;

    logic        mclk_i = 1'b0;
    logic        rst_i  = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        poll, poll_out, rel, keep, stat, din_oe, msel, err;
    logic [7:0]  acc, din;
    logic [13:0] maddr = 14'h0, dma_addr, exp_addr = 14'h0;
    logic        claim = 1'b0, claim_run = 1'b0, claim_prev = 1'b0, dma_stb, dma_busy, dma_dir = 1'b0;
    logic [1:0]  claim_ph = 2'h0;
    int          err_count = 0, checks_done = 0, stb_n = 0;
    logic [13:0] at [5] = '{14'h0000, 14'h1fff, 14'h2000, 14'h2fff, 14'h3000};

    always #2.5 mclk_i = ~mclk_i;

    ipb_card #(.DEV_ADDR(TB_DEV), .SECTOR(TB_SECT)) dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .poll_i(poll), .poll_o(poll_out), .transfer_release_cmd_i(rel), .transfer_keep_cmd_i(keep),
        .status_cmd_i(stat), .cpu_output_data_bus_i(acc), .cpu_input_data_bus_o(din),
        .cpu_input_data_oe_o(din_oe), .memory_address_bus_i(maddr), .mem_select_o(msel),
        .cpu_claim_i(claim), .dma_addr_o(dma_addr), .dma_strobe_o(dma_stb), .dma_busy_o(dma_busy));

    ipb_cpu_model cpu_u (
        .mclk_i(mclk_i), .oe_i(din_oe), .bus_i(din), .poll_next_i(poll_out),
        .poll_o(poll), .release_o(rel), .keep_o(keep), .status_o(stat), .acc_o(acc));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("FAIL apb wait expected ready seen none");
            print_verdict();
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic eo, input logic [7:0] eb,
                       input logic ep, input logic [7:0] m = 8'hff);
        logic       oe;
        logic       ps;
        logic [7:0] d;
        cpu_u.issue(op, a, oe, d, ps);
        chk("card answer", {22'h0, eo, ep, eb & m}, {22'h0, oe, ps, d & m});
    endtask

    // the processor claims one cycle in four, so the dma sees both stalls and back-to-back slots
    always @(posedge mclk_i) begin
        claim_ph <= claim_ph + 2'h1;
        claim    <= claim_run && claim_ph == 2'h0;
    end

    always @(negedge mclk_i) begin
        if (dma_stb === 1'b1) begin
            stb_n++;
            chk("dma addr", {18'h0, exp_addr}, {18'h0, dma_addr});
            chk("dma while claimed", 32'h0, {31'h0, claim_prev});
            exp_addr = dma_dir ? exp_addr - 14'h1 : exp_addr + 14'h1;
        end
        claim_prev = claim;
    end

    task automatic dma_run(input logic [13:0] start, input logic [13:0] cnt, input logic down);
        int n;
        stb_n    = 0;
        exp_addr = start;
        dma_dir  = down;
        apb(1'b1, OFS_DMA_START, {18'h0, start});
        apb(1'b1, OFS_DMA_COUNT, {18'h0, cnt});
        claim_run <= 1'b1;
        apb(1'b1, OFS_DMA_CTRL, {30'h0, down, 1'b1});
        rd_chk("dma ctrl", OFS_DMA_CTRL, {30'h0, down, cnt != 14'h0});
        n = 0;
        while (stb_n < int'(cnt) && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 200) begin
            err_count++;
            $display("FAIL dma wait expected %0d strobes seen %0d", cnt, stb_n);
            print_verdict();
        end
        repeat (3) @(posedge mclk_i);
        claim_run <= 1'b0;
        chk("dma transfers", {18'h0, cnt}, stb_n);
        chk("dma busy", 32'h0, {31'h0, dma_busy});
        cmd(QRY, 8'h00, 1'b1, {3'b101, TB_DEV}, 1'b0);
        cmd(REL, 8'h77, 1'b1, 8'h77, 1'b0);
        $display("test dma done");
    endtask

    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd_chk("ctrl", OFS_CTRL, {19'h0, TB_DEV, 8'h00});
        rd_chk("status", OFS_STATUS, 32'hc0);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h80000000, {err, rd[30:0]});
        cmd(QRY, 8'h00, 1'b0, 8'h00, 1'b1);
        cmd(REL, 8'h00, 1'b0, 8'h00, 1'b0);
        $display("test idle done");

        apb(1'b1, OFS_TXDATA, 32'h5a);
        cmd(QRY, 8'h00, 1'b1, {3'b110, TB_DEV}, 1'b0);
        rd_chk("status", OFS_STATUS, 32'hd9);
        cmd(KEP, 8'h33, 1'b1, 8'h5a, 1'b0);
        rd_chk("status", OFS_STATUS, 32'hc3);
        cmd(REL, 8'h44, 1'b1, 8'h44, 1'b0);
        rd_chk("rx data", OFS_RXDATA, 32'h44);
        cmd(REL, 8'h55, 1'b0, 8'h00, 1'b0);
        rd_chk("status", OFS_STATUS, 32'hc0);
        $display("test exchange done");

        apb(1'b1, OFS_CTRL, {19'h0, TB_DEV, 8'h01});
        for (int i = 0; i < 2; i++) begin
            cmd(STS, (i == 0 ? 8'h40 : 8'h80) | TB_DEV, 1'b1, (i == 0 ? 8'hd0 : 8'h50), 1'b0);
            cmd(QRY, 8'h00, 1'b0, 8'h00, 1'b1);
            cmd(REL, 8'h00, 1'b0, 8'h00, 1'b0);
        end
        cmd(STS, 8'hc0 | (TB_DEV ^ 5'h01), 1'b0, 8'h00, 1'b0);
        cmd(STS, 8'he0 | TB_DEV, 1'b1, 8'h90, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("enables", 32'h2, {30'h0, rd[7:6]});
        cmd(STS, 8'hc0 | TB_DEV, 1'b1, 8'h90, 1'b0, 8'hdf);
        cmd(QRY, 8'h00, 1'b1, {3'b100, TB_DEV}, 1'b0);
        cmd(STS, 8'hc0 | TB_DEV, 1'b1, 8'hd1, 1'b0, 8'hdf);
        cmd(REL, 8'h66, 1'b0, 8'h00, 1'b0);
        apb(1'b1, OFS_CTRL, {19'h0, TB_DEV, 8'h00});
        $display("test status done");

        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_i);
            maddr <= at[i];
            @(posedge mclk_i);
            @(posedge mclk_i);
            chk("sector select", {31'h0, at[i][13:12] == TB_SECT}, {31'h0, msel});
        end
        $display("test sector done");

        dma_run(14'h0ffe, 14'h3, 1'b0);
        dma_run(14'h0001, 14'h2, 1'b1);
        dma_run(14'h0100, 14'h0, 1'b0);
        print_verdict();
    end
endmodule

// ==== tb/ipb_cpu_model.sv ====
// processor side model: issues query, exchange and status commands on the card bus
`timescale 1ns/1ps
module ipb_cpu_model (
    // clock
    input  wire logic       mclk_i,
    // card answer
    input  wire logic       oe_i,
    input  wire logic [7:0] bus_i,
    input  wire logic       poll_next_i,
    // commands
    output logic            poll_o,
    output logic            release_o,
    output logic            keep_o,
    output logic            status_o,
    output logic [7:0]      acc_o
);
    localparam logic [1:0] OP_QUERY   = 2'h0;
    localparam logic [1:0] OP_RELEASE = 2'h1;
    localparam logic [1:0] OP_STATUS  = 2'h2;
    localparam logic [1:0] OP_KEEP    = 2'h3;

    initial begin
        {poll_o, release_o, keep_o, status_o} = 4'h0;
        acc_o = 8'h00;
    end

    // accumulator is scrambled once the command is over, so a late capture by the card shows garbage
    task automatic issue(input logic [1:0] op, input logic [7:0] acc, output logic oe, output logic [7:0] d,
                         output logic passed);
        @(posedge mclk_i);
        acc_o     <= acc;
        poll_o    <= (op == OP_QUERY);
        release_o <= (op == OP_RELEASE);
        keep_o    <= (op == OP_KEEP);
        status_o  <= (op == OP_STATUS);
        @(posedge mclk_i);
        {poll_o, release_o, keep_o, status_o} <= 4'h0;
        acc_o <= ~acc;
        @(posedge mclk_i);
        oe     = oe_i;
        d      = bus_i;
        passed = poll_next_i;
    endtask
endmodule

// ==== verilog/ipb_card.sv ====
// i/o bus card: service query chain, exchange and status commands, sector decode, dma
`timescale 1ns/1ps
module ipb_card #(
    parameter logic [4:0] DEV_ADDR = ipb_pkg::DEV_ADDR_RST,
    parameter logic [1:0] SECTOR   = ipb_pkg::SECTOR_RST
) (
    // clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        rst_i,
    // apb slave
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [7:0]                  paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic [31:0]                      prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    // processor i/o bus
    input  wire logic                        poll_i,
    output logic                             poll_o,
    input  wire logic                        transfer_release_cmd_i,
    input  wire logic                        transfer_keep_cmd_i,
    input  wire logic                        status_cmd_i,
    input  wire logic [ipb_pkg::BYTE_W-1:0]  cpu_output_data_bus_i,
    output logic [ipb_pkg::BYTE_W-1:0]       cpu_input_data_bus_o,
    output logic                             cpu_input_data_oe_o,
    // memory sector
    input  wire logic [ipb_pkg::MEM_AW-1:0]  memory_address_bus_i,
    output logic                             mem_select_o,
    // dma
    input  wire logic                        cpu_claim_i,
    output logic [ipb_pkg::MEM_AW-1:0]       dma_addr_o,
    output logic                             dma_strobe_o,
    output logic                             dma_busy_o
);
    import ipb_pkg::*;

    ipb_card_st_t s_reg, s_next;

    logic       sec_hit;
    logic       dma_done_pulse;
    logic       ready_w;
    logic       want_w;
    logic       addr_match;
    logic       xchg;
    logic       apb_done;
    logic [2:0] status3;
    logic [7:0] stat_reply;
    logic [7:0] acc;

    ipb_sector #(
        .SECTOR (SECTOR)
    ) u_sector (
        .addr_i (memory_address_bus_i),
        .hit_o  (sec_hit)
    );

    ipb_dma #(
        .AW (MEM_AW),
        .CW (DMA_CW)
    ) u_dma (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .start_i      (s_reg.dma_go),
        .start_addr_i (s_reg.dma_start),
        .count_i      (s_reg.dma_count),
        .down_i       (s_reg.dma_down),
        .cpu_claim_i  (cpu_claim_i),
        .addr_o       (dma_addr_o),
        .strobe_o     (dma_strobe_o),
        .busy_o       (dma_busy_o),
        .done_o       (dma_done_pulse)
    );

    assign acc        = cpu_output_data_bus_i;
    assign ready_w    = s_reg.tx_valid | s_reg.rx_want | s_reg.dma_done;
    // a switched-off card never claims the query, whatever it holds
    assign want_w     = ready_w & s_reg.dev_on & s_reg.poll_on & ~s_reg.sel;
    assign status3    = {ready_w, s_reg.tx_valid, s_reg.dma_done};
    assign stat_reply = {s_reg.dev_on, s_reg.poll_on, s_reg.wp, status3, s_reg.rx_full, s_reg.sel};
    assign addr_match = (acc[DEV_AW-1:0] == s_reg.dev_addr);
    assign xchg       = transfer_release_cmd_i | transfer_keep_cmd_i;
    assign apb_done   = psel_i & penable_i & s_reg.pready;

    always_comb begin
        s_next         = s_reg;
        s_next.din     = '0;
        s_next.din_oe  = 1'b0;
        s_next.dma_go  = 1'b0;
        s_next.mem_sel = sec_hit;
        s_next.pready  = psel_i & penable_i & ~s_reg.pready;
        // the chain is re-timed here, so each card adds one cycle of query delay
        s_next.poll_out = poll_i & ~want_w;

        // a read of received data frees the buffer; a same-cycle capture below wins
        if (apb_done && !pwrite_i && paddr_i == OFS_RXDATA) begin
            s_next.rx_full = 1'b0;
        end

        if (status_cmd_i) begin
            if (addr_match) begin
                s_next.din    = stat_reply;
                s_next.din_oe = 1'b1;
                s_next.sel    = 1'b0;
                s_next.wp     = acc[ACC_WP_BIT];
                if (!acc[ACC_WP_BIT]) begin
                    s_next.dev_on  = acc[ACC_DEV_BIT];
                    s_next.poll_on = acc[ACC_POLL_BIT];
                end
            end
        end else if (xchg) begin
            if (s_reg.sel) begin
                s_next.rx_data  = acc;
                s_next.rx_full  = 1'b1;
                s_next.din      = s_reg.tx_valid ? s_reg.tx_data : acc;
                s_next.din_oe   = 1'b1;
                s_next.tx_valid = 1'b0;
                s_next.rx_want  = 1'b0;
                s_next.dma_done = 1'b0;
                if (transfer_release_cmd_i) begin
                    s_next.sel = 1'b0;
                end
            end
        end else if (poll_i && want_w) begin
            s_next.sel    = 1'b1;
            s_next.din    = {status3, s_reg.dev_addr};
            s_next.din_oe = 1'b1;
        end

        if (dma_done_pulse) begin
            s_next.dma_done = 1'b1;
        end

        if (s_next.pready) begin
            s_next.pslverr = 1'b0;
            case (paddr_i)
                OFS_CTRL:      s_next.prdata = {19'h0, s_reg.dev_addr, 7'h0, s_reg.rx_want};
                OFS_TXDATA:    s_next.prdata = {24'h0, s_reg.tx_data};
                OFS_RXDATA:    s_next.prdata = {24'h0, s_reg.rx_data};
                OFS_STATUS:    s_next.prdata = {24'h0, stat_reply};
                OFS_DMA_START: s_next.prdata = {18'h0, s_reg.dma_start};
                OFS_DMA_COUNT: s_next.prdata = {18'h0, s_reg.dma_count};
                OFS_DMA_CTRL:  s_next.prdata = {30'h0, s_reg.dma_down, dma_busy_o};
                default: begin
                    s_next.prdata  = '0;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end

        // software writes come last so that a write beats any same-cycle hardware update, including a go write clearing dma_done
        if (apb_done && pwrite_i) begin
            case (paddr_i)
                OFS_CTRL: begin
                    s_next.rx_want  = pwdata_i[CTRL_RXWANT_BIT];
                    s_next.dev_addr = pwdata_i[CTRL_ADDR_LSB +: DEV_AW];
                end
                OFS_TXDATA: begin
                    s_next.tx_data  = pwdata_i[BYTE_W-1:0];
                    s_next.tx_valid = 1'b1;
                end
                OFS_DMA_START: s_next.dma_start = pwdata_i[MEM_AW-1:0];
                OFS_DMA_COUNT: s_next.dma_count = pwdata_i[DMA_CW-1:0];
                OFS_DMA_CTRL: begin
                    s_next.dma_down = pwdata_i[DMA_DOWN_BIT];
                    s_next.dma_go   = pwdata_i[DMA_GO_BIT];
                    if (pwdata_i[DMA_GO_BIT]) begin
                        s_next.dma_done = 1'b0;
                    end
                end
                default: s_next.dma_go = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_reg          <= '0;
            s_reg.dev_on   <= DEV_ON_RST;
            s_reg.poll_on  <= POLL_ON_RST;
            s_reg.wp       <= WP_RST;
            s_reg.dev_addr <= DEV_ADDR;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_o             = s_reg.prdata;
    assign pready_o             = s_reg.pready;
    assign pslverr_o            = s_reg.pslverr;
    assign poll_o               = s_reg.poll_out;
    assign cpu_input_data_bus_o = s_reg.din;
    assign cpu_input_data_oe_o  = s_reg.din_oe;
    assign mem_select_o         = s_reg.mem_sel;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence q_claim;
        poll_i && want_w && !status_cmd_i && !xchg;
    endsequence
    sequence q_addressed;
        status_cmd_i && addr_match;
    endsequence

    a_poll_pass: assert property (poll_i && !want_w |-> ##1 poll_o)
        else $error("query not passed on");
    a_poll_block: assert property (q_claim |-> ##1 !poll_o && s_reg.sel && cpu_input_data_oe_o)
        else $error("ready card did not block and select");
    a_poll_reply: assert property (q_claim |-> ##1 cpu_input_data_bus_o == {$past(status3), $past(s_reg.dev_addr)})
        else $error("query reply wrong");
    a_idle_zero: assert property (!cpu_input_data_oe_o |-> cpu_input_data_bus_o == 8'h00)
        else $error("bus not zero when idle");
    a_release_desel: assert property (s_reg.sel && transfer_release_cmd_i && !status_cmd_i
        |-> ##1 !s_reg.sel && s_reg.rx_data == $past(acc))
        else $error("release did not capture and deselect");
    a_keep_hold: assert property (s_reg.sel && transfer_keep_cmd_i && !transfer_release_cmd_i && !status_cmd_i
        |-> ##1 s_reg.sel && cpu_input_data_oe_o)
        else $error("holding exchange lost selection");
    a_status_miss: assert property (status_cmd_i && !addr_match |-> ##1 !cpu_input_data_oe_o)
        else $error("unaddressed card answered status");
    a_status_write: assert property (q_addressed and acc[ACC_WP_BIT] == 1'b0
        |-> ##1 s_reg.dev_on == $past(acc[ACC_DEV_BIT]) && s_reg.poll_on == $past(acc[ACC_POLL_BIT]))
        else $error("status bits not written");
    a_status_prot: assert property (q_addressed and acc[ACC_WP_BIT] == 1'b1
        |-> ##1 $stable(s_reg.dev_on) && $stable(s_reg.poll_on))
        else $error("protected enables changed");
    a_status_reply: assert property (q_addressed |-> ##1 cpu_input_data_oe_o
        && cpu_input_data_bus_o == $past(stat_reply))
        else $error("status reply wrong");
    a_off_pass: assert property (poll_i && !(s_reg.dev_on && s_reg.poll_on) |-> ##1 poll_o)
        else $error("disabled card blocked query");
    a_sector_sel: assert property (##1 mem_select_o == ($past(memory_address_bus_i[13:12]) == SECTOR))
        else $error("sector select wrong");
    a_dma_ready: assert property (dma_done_pulse && !xchg |-> ##1 s_reg.dma_done && ready_w)
        else $error("finished dma block not ready");
endmodule

// ==== verilog/ipb_dma.sv ====
// block dma sequencer: walks the address up or down for a programmed count
`timescale 1ns/1ps
module ipb_dma #(
    parameter int AW = ipb_pkg::MEM_AW,
    parameter int CW = ipb_pkg::DMA_CW
) (
    // clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    // setup
    input  wire logic          start_i,
    input  wire logic [AW-1:0] start_addr_i,
    input  wire logic [CW-1:0] count_i,
    input  wire logic          down_i,
    // bus sharing
    input  wire logic          cpu_claim_i,
    // transfer
    output logic [AW-1:0]      addr_o,
    output logic               strobe_o,
    output logic               busy_o,
    output logic               done_o
);
    import ipb_pkg::*;

    typedef struct packed {
        ipb_dma_state_t state;
        logic [AW-1:0]  addr;
        logic [AW-1:0]  xaddr;
        logic [CW-1:0]  left;
        logic           down;
        logic           strobe;
        logic           done;
        logic           busy;
    } ipb_dma_st_t;

    ipb_dma_st_t s_reg, s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.strobe = 1'b0;
        s_next.done   = 1'b0;
        case (s_reg.state)
            IPB_DMA_IDLE: begin
                if (start_i) begin
                    s_next.addr  = start_addr_i;
                    s_next.left  = count_i;
                    s_next.down  = down_i;
                    s_next.state = (count_i == '0) ? IPB_DMA_DONE : IPB_DMA_RUN;
                end
            end
            IPB_DMA_RUN: begin
                // only slots the processor leaves free are used
                if (!cpu_claim_i) begin
                    s_next.strobe = 1'b1;
                    s_next.xaddr  = s_reg.addr;
                    s_next.addr   = s_reg.down ? s_reg.addr - 1'b1 : s_reg.addr + 1'b1;
                    s_next.left   = s_reg.left - 1'b1;
                    if (s_reg.left == {{(CW-1){1'b0}}, 1'b1}) begin
                        s_next.state = IPB_DMA_DONE;
                    end
                end
            end
            IPB_DMA_DONE: begin
                s_next.done  = 1'b1;
                s_next.state = IPB_DMA_IDLE;
            end
            default: s_next.state = IPB_DMA_IDLE;
        endcase
        // busy is registered so the card can hand it straight to a pin
        s_next.busy = (s_next.state == IPB_DMA_RUN);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign addr_o   = s_reg.xaddr;
    assign strobe_o = s_reg.strobe;
    assign busy_o   = s_reg.busy;
    assign done_o   = s_reg.done;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_dma_yield: assert property (strobe_o |-> $past(cpu_claim_i) == 1'b0)
        else $error("dma used a cycle the processor claimed");
    a_dma_step: assert property (strobe_o ##1 strobe_o |->
        addr_o == (s_reg.down ? $past(addr_o) - 1'b1 : $past(addr_o) + 1'b1))
        else $error("dma address did not step by one");
    a_dma_last: assert property (s_reg.state == IPB_DMA_RUN && s_reg.left == 1 && !cpu_claim_i
        |-> ##1 strobe_o ##1 done_o)
        else $error("dma did not stop after last transfer");
endmodule

// ==== verilog/ipb_pkg.sv ====
// shared constants and types for the i/o bus poll interface card
package ipb_pkg;
    // bus widths and memory map
    localparam int        MEM_AW        = 14;
    localparam int        BYTE_W        = 8;
    localparam int        DEV_AW        = 5;
    localparam int        SECTOR_W      = 2;
    localparam int        SECTOR_BYTES  = 4096;
    localparam int        DMA_CW        = 14;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_TXDATA    = 8'h04;
    localparam logic [7:0] OFS_RXDATA    = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0c;
    localparam logic [7:0] OFS_DMA_START = 8'h10;
    localparam logic [7:0] OFS_DMA_COUNT = 8'h14;
    localparam logic [7:0] OFS_DMA_CTRL  = 8'h18;
    // field positions
    localparam int        CTRL_RXWANT_BIT = 0;
    localparam int        CTRL_ADDR_LSB   = 8;
    localparam int        DMA_GO_BIT      = 0;
    localparam int        DMA_DOWN_BIT    = 1;
    localparam int        ACC_WP_BIT      = 5;
    localparam int        ACC_POLL_BIT    = 6;
    localparam int        ACC_DEV_BIT     = 7;
    // reset values
    localparam logic [4:0] DEV_ADDR_RST = 5'h01;
    localparam logic [1:0] SECTOR_RST   = 2'h0;
    localparam logic       DEV_ON_RST   = 1'b1;
    localparam logic       POLL_ON_RST  = 1'b1;
    localparam logic       WP_RST       = 1'b0;

    typedef enum logic [1:0] {
        IPB_DMA_IDLE = 2'b00,
        IPB_DMA_RUN  = 2'b01,
        IPB_DMA_DONE = 2'b11
    } ipb_dma_state_t;

    typedef struct packed {
        logic        sel;
        logic        dev_on;
        logic        poll_on;
        logic        wp;
        logic [4:0]  dev_addr;
        logic        rx_want;
        logic        tx_valid;
        logic [7:0]  tx_data;
        logic        rx_full;
        logic [7:0]  rx_data;
        logic        dma_done;
        logic        poll_out;
        logic [7:0]  din;
        logic        din_oe;
        logic        mem_sel;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [13:0] dma_start;
        logic [13:0] dma_count;
        logic        dma_down;
        logic        dma_go;
    } ipb_card_st_t;
endpackage

// ==== verilog/ipb_sector.sv ====
// memory card sector match on the top address bits
`timescale 1ns/1ps
module ipb_sector #(
    parameter logic [1:0] SECTOR = ipb_pkg::SECTOR_RST
) (
    // address
    input  wire logic [ipb_pkg::MEM_AW-1:0] addr_i,
    // match
    output logic                            hit_o
);
    import ipb_pkg::*;

    // 4096 bytes per sector, so the two top bits of the 14-bit address pick it
    assign hit_o = (addr_i[MEM_AW-1 -: SECTOR_W] == SECTOR);
endmodule
